// file: pkg/ppc_map.vh
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

// register byte addresses
`define PPC_ADDR_PU0      16'hff30
`define PPC_ADDR_PU2      16'hff32
`define PPC_ADDR_PU3      16'hff33
`define PPC_ADDR_PU4      16'hff34
`define PPC_ADDR_PU5      16'hff35
`define PPC_ADDR_PU6      16'hff36
`define PPC_ADDR_PU7      16'hff37
`define PPC_ADDR_PULLUP_SEL_PORT12     16'hff3c
`define PPC_ADDR_P4MODE   16'hff47
`define PPC_ADDR_PF8      16'hff58
`define PPC_ADDR_PF9      16'hff59
`define PPC_ADDR_KRGRP    16'hff8f

// implemented bit masks, unimplemented bits read zero
`define PPC_MASK_PU0      8'h3f
`define PPC_MASK_PU2      8'h3f
`define PPC_MASK_PU3      8'h1f
`define PPC_MASK_PU4      8'hff
`define PPC_MASK_PU5      8'hff
`define PPC_MASK_PU6      8'hf0
`define PPC_MASK_PU7      8'h0f
`define PPC_MASK_PULLUP_SEL_PORT12     8'h01
`define PPC_MASK_P4MODE   8'h07
`define PPC_MASK_KRGRP    8'h01

// reset values
`define PPC_RST_BYTE      8'h00
`define PPC_RST_DIR       8'hff

// port 4 mode codes
`define PPC_P4_SINGLE     3'h0
`define PPC_P4_KEYRET     3'h1

// pin function codes
`define PPC_PF_SEGMENT    8'h00
`define PPC_PF_OUTPORT    8'hff

// key return pin groups
`define PPC_KR_ALL        8'hff
`define PPC_KR_LOW        8'h0f
`define PPC_KR_NONE       8'h00

`endif

// file: rtl/ppc_top.v
// Behaviour
// - a set pull-up bit connects the pull-up in input and output mode
// - pull-up bit n drives pin n; 1 connects; unimplemented bits read zero
// - port 1 has no pull-ups; port 6 low pins only by mask option
// - port 4 mode bits 2..0: 000 single-chip, 001 key-return, rest prohibited
// - port 4 mode and key group registers take bit and byte writes, reset 00h
// - key-return mode detects falling edges on port 4 pins
// - group bit 0 uses all eight pins, 1 only the lower four
// - key group register resets 00h, only bit 0 implemented
// - key group bit is written once after reset
// - pin function registers are write-only, byte writes only, reset 00h
// - pin function 00h selects lcd segments, ffh output-only port
// - pin function written once, only with 00h or ffh
// - direction bit 0 enables output buffer, 1 input, reset all ones
`timescale 1ns/1ps
`include "ppc_map.vh"

module ppc_pu_reg #(
   parameter [15:0] ADDR = 16'h0000,
   parameter [7:0]  MASK = 8'hff
) (
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire [15:0] addr_in,
   input  wire        wr_in,
   input  wire        bit_in,
   input  wire [2:0]  bit_sel_in,
   input  wire [7:0]  wdata_in,
   output wire [7:0]  q_out
);

   reg  [7:0] q_q;
   reg  [7:0] q_d;
   wire [7:0] bit_mask;

   assign bit_mask = 8'h01 << bit_sel_in;
   assign q_out    = q_q;

   always @* begin
      q_d = q_q;
      if (wr_in && (addr_in == ADDR)) begin
         if (bit_in) begin
            q_d = (q_q & ~bit_mask) | (wdata_in[0] ? bit_mask : 8'h00);
         end else begin
            q_d = wdata_in;
         end
      end
      q_d = q_d & MASK;
   end

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         q_q <= `PPC_RST_BYTE;
      end else begin
         q_q <= q_d;
      end
   end

endmodule

module ppc_top #(
   parameter [3:0] P6_LOW_PU = 4'h0
) (
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire [15:0] cpu_addr_in,
   input  wire        cpu_wr_in,
   input  wire        cpu_bit_in,
   input  wire [2:0]  cpu_bit_sel_in,
   input  wire [7:0]  cpu_wdata_in,
   input  wire        cpu_rd_in,
   output reg  [7:0]  cpu_rdata_out,
   input  wire [7:0]  port4_pins_in,
   input  wire [7:0]  port8_direction_in,
   input  wire [7:0]  port9_direction_in,
   output wire [7:0]  pullup_p0_out,
   output wire [7:0]  pullup_p2_out,
   output wire [7:0]  pullup_p3_out,
   output wire [7:0]  pullup_p4_out,
   output wire [7:0]  pullup_p5_out,
   output reg  [7:0]  pullup_p6_out,
   output wire [7:0]  pullup_p7_out,
   output wire [7:0]  pullup_p12_out,
   output reg         port4_key_mode_out,
   output reg  [7:0]  key_pins_out,
   output reg         key_return_out,
   output reg  [7:0]  key_edge_out,
   output reg         port8_segment_out,
   output reg         port9_segment_out,
   output reg  [7:0]  port8_drive_out,
   output reg  [7:0]  port9_drive_out
);

   wire [7:0] pu0;
   wire [7:0] pu2;
   wire [7:0] pu3;
   wire [7:0] pu4;
   wire [7:0] pu5;
   wire [7:0] pu6;
   wire [7:0] pu7;
   wire [7:0] pullup_sel_port12;

   reg  [2:0] p4_mode_q;
   reg  [2:0] p4_mode_d;
   reg        kr_group_q;
   reg        kr_group_d;
   reg        kr_lock_q;
   reg        kr_lock_d;
   reg  [7:0] pf8_q;
   reg  [7:0] pf8_d;
   reg        pf8_lock_q;
   reg        pf8_lock_d;
   reg  [7:0] pf9_q;
   reg  [7:0] pf9_d;
   reg        pf9_lock_q;
   reg        pf9_lock_d;
   reg  [7:0] pins_prev_q;
   reg  [7:0] rdata_d;
   reg  [7:0] key_mask_d;
   reg  [7:0] merged;

   wire [7:0] bit_mask;
   wire       wr_mode;
   wire       wr_kr;
   wire       wr_pf8;
   wire       wr_pf9;
   wire       pf_code_ok;
   wire [7:0] edges;

   assign bit_mask = 8'h01 << cpu_bit_sel_in;
   assign wr_mode  = cpu_wr_in && (cpu_addr_in == `PPC_ADDR_P4MODE);
   assign wr_kr    = cpu_wr_in && (cpu_addr_in == `PPC_ADDR_KRGRP);
   assign wr_pf8   = cpu_wr_in && !cpu_bit_in && (cpu_addr_in == `PPC_ADDR_PF8);
   assign wr_pf9   = cpu_wr_in && !cpu_bit_in && (cpu_addr_in == `PPC_ADDR_PF9);
   assign pf_code_ok = (cpu_wdata_in == `PPC_PF_SEGMENT) ||
                       (cpu_wdata_in == `PPC_PF_OUTPORT);

   // pull-up follows its bit, direction is not looked at
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU0), .MASK(`PPC_MASK_PU0)) u_pu0 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu0)
   );
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU2), .MASK(`PPC_MASK_PU2)) u_pu2 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu2)
   );
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU3), .MASK(`PPC_MASK_PU3)) u_pu3 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu3)
   );
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU4), .MASK(`PPC_MASK_PU4)) u_pu4 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu4)
   );
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU5), .MASK(`PPC_MASK_PU5)) u_pu5 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu5)
   );
   // port 6 keeps only the upper four selects
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU6), .MASK(`PPC_MASK_PU6)) u_pu6 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu6)
   );
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PU7), .MASK(`PPC_MASK_PU7)) u_pu7 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pu7)
   );
   ppc_pu_reg #(.ADDR(`PPC_ADDR_PULLUP_SEL_PORT12), .MASK(`PPC_MASK_PULLUP_SEL_PORT12)) u_pullup_sel_port12 (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .addr_in    (cpu_addr_in),
      .wr_in      (cpu_wr_in),
      .bit_in     (cpu_bit_in),
      .bit_sel_in (cpu_bit_sel_in),
      .wdata_in   (cpu_wdata_in),
      .q_out      (pullup_sel_port12)
   );

   assign pullup_p0_out  = pu0;
   assign pullup_p2_out  = pu2;
   assign pullup_p3_out  = pu3;
   assign pullup_p4_out  = pu4;
   assign pullup_p5_out  = pu5;
   assign pullup_p7_out  = pu7;
   assign pullup_p12_out = pullup_sel_port12;

   // merged byte for the bit-wide path of mode and key group registers
   always @* begin
      if (cpu_bit_in) begin
         merged = bit_mask & {8{cpu_wdata_in[0]}};
      end else begin
         merged = cpu_wdata_in;
      end
   end

   always @* begin
      p4_mode_d  = p4_mode_q;
      kr_group_d = kr_group_q;
      kr_lock_d  = kr_lock_q;
      pf8_d      = pf8_q;
      pf8_lock_d = pf8_lock_q;
      pf9_d      = pf9_q;
      pf9_lock_d = pf9_lock_q;
      // bit write touches only the addressed bit
      if (wr_mode) begin
         if (cpu_bit_in) begin
            if (cpu_bit_sel_in < 3'h3) begin
               p4_mode_d = (p4_mode_q & ~bit_mask[2:0]) | merged[2:0];
            end
         end else begin
            p4_mode_d = merged[2:0];
         end
      end
      // first write locks the group bit
      if (wr_kr && !kr_lock_q) begin
         kr_lock_d = 1'b1;
         if (!cpu_bit_in || (cpu_bit_sel_in == 3'h0)) begin
            kr_group_d = merged[0];
         end
      end
      // a prohibited code neither stores nor locks
      if (wr_pf8 && !pf8_lock_q && pf_code_ok) begin
         pf8_d      = cpu_wdata_in;
         pf8_lock_d = 1'b1;
      end
      if (wr_pf9 && !pf9_lock_q && pf_code_ok) begin
         pf9_d      = cpu_wdata_in;
         pf9_lock_d = 1'b1;
      end
   end

   // group bit picks eight or four pins
   always @* begin
      key_mask_d = `PPC_KR_NONE;
      case (p4_mode_q)
         `PPC_P4_KEYRET: begin
            key_mask_d = kr_group_q ? `PPC_KR_LOW : `PPC_KR_ALL;
         end
         default: begin
            key_mask_d = `PPC_KR_NONE;
         end
      endcase
   end

   // falling edge on a participating pin
   assign edges = pins_prev_q & ~port4_pins_in & key_mask_d;

   always @* begin
      rdata_d = 8'h00;
      case (cpu_addr_in)
         `PPC_ADDR_PU0:    rdata_d = pu0;
         `PPC_ADDR_PU2:    rdata_d = pu2;
         `PPC_ADDR_PU3:    rdata_d = pu3;
         `PPC_ADDR_PU4:    rdata_d = pu4;
         `PPC_ADDR_PU5:    rdata_d = pu5;
         `PPC_ADDR_PU6:    rdata_d = pu6;
         `PPC_ADDR_PU7:    rdata_d = pu7;
         `PPC_ADDR_PULLUP_SEL_PORT12:   rdata_d = pullup_sel_port12;
         `PPC_ADDR_P4MODE: rdata_d = {5'h00, p4_mode_q};
         `PPC_ADDR_KRGRP:  rdata_d = {7'h00, kr_group_q};
         default:          rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk_in) begin
      if (!nrst_in) begin
         p4_mode_q          <= 3'h0;
         kr_group_q         <= 1'b0;
         kr_lock_q          <= 1'b0;
         pf8_q              <= `PPC_RST_BYTE;
         pf8_lock_q         <= 1'b0;
         pf9_q              <= `PPC_RST_BYTE;
         pf9_lock_q         <= 1'b0;
         pins_prev_q        <= 8'hff;
         cpu_rdata_out      <= 8'h00;
         pullup_p6_out      <= 8'h00;
         port4_key_mode_out <= 1'b0;
         key_pins_out       <= 8'h00;
         key_return_out     <= 1'b0;
         key_edge_out       <= 8'h00;
         port8_segment_out  <= 1'b1;
         port9_segment_out  <= 1'b1;
         port8_drive_out    <= 8'h00;
         port9_drive_out    <= 8'h00;
      end else begin
         p4_mode_q          <= p4_mode_d;
         kr_group_q         <= kr_group_d;
         kr_lock_q          <= kr_lock_d;
         pf8_q              <= pf8_d;
         pf8_lock_q         <= pf8_lock_d;
         pf9_q              <= pf9_d;
         pf9_lock_q         <= pf9_lock_d;
         pins_prev_q        <= port4_pins_in;
         if (cpu_rd_in) begin
            cpu_rdata_out <= rdata_d;
         end
         // low port 6 pull-ups come only from the mask option
         pullup_p6_out      <= {pu6[7:4], P6_LOW_PU};
         port4_key_mode_out <= (p4_mode_q == `PPC_P4_KEYRET);
         key_pins_out       <= key_mask_d;
         key_return_out     <= |edges;
         key_edge_out       <= edges;
         port8_segment_out  <= (pf8_q != `PPC_PF_OUTPORT);
         port9_segment_out  <= (pf9_q != `PPC_PF_OUTPORT);
         // direction 0 turns the output buffer on
         port8_drive_out    <= (pf8_q == `PPC_PF_OUTPORT) ? ~port8_direction_in : 8'h00;
         port9_drive_out    <= (pf9_q == `PPC_PF_OUTPORT) ? ~port9_direction_in : 8'h00;
      end
   end

endmodule

// file: tb/ppc_pin_model.sv
`timescale 1ns/1ps
// key pad on port 4: a pressed key pulls its pin low, released pins sit at the pull-up level
module ppc_pin_model (
   input  wire       clk_in,
   input  wire [7:0] press_in,
   output reg  [7:0] pins_out
);
   initial pins_out = 8'hff;
   always @(posedge clk_in) begin
      pins_out <= ~press_in;
   end
endmodule

// file: tb/ppc_top_props.sv
`timescale 1ns/1ps
module ppc_top_props #(
   parameter [3:0] P6_LOW_PU = 4'h0
) (
   input wire        clk_in,
   input wire        nrst_in,
   input wire [15:0] cpu_addr_in,
   input wire        cpu_wr_in,
   input wire        cpu_bit_in,
   input wire [7:0]  cpu_wdata_in,
   input wire        cpu_rd_in,
   input wire [7:0]  cpu_rdata_out,
   input wire [7:0]  port4_pins_in,
   input wire [7:0]  pullup_p4_out,
   input wire [7:0]  pullup_p6_out,
   input wire        port4_key_mode_out,
   input wire [7:0]  key_pins_out,
   input wire        key_return_out,
   input wire [7:0]  key_edge_out,
   input wire        port8_segment_out,
   input wire [7:0]  port8_drive_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_kr_pulse;
      (key_edge_out != 8'h00) |=> ((key_edge_out & $past(key_edge_out)) == 8'h00);
   endproperty
   a_kr_pulse: assert property (p_kr_pulse) else $error("same pin edge on two cycles running");
   property p_kr_edge;
      key_return_out == (key_edge_out != 8'h00);
   endproperty
   a_kr_edge: assert property (p_kr_edge) else $error("key return and edge bits disagree");
   property p_edge_pins;
      (key_edge_out != 8'h00) |-> ((key_edge_out & $past(port4_pins_in)) == 8'h00)
         && ((key_edge_out & ~$past(port4_pins_in, 2)) == 8'h00);
   endproperty
   a_edge_pins: assert property (p_edge_pins) else $error("edge without high then low");
   property p_keypins;
      (key_pins_out inside {8'hff, 8'h0f, 8'h00})
         && (port4_key_mode_out == (key_pins_out != 8'h00));
   endproperty
   a_keypins: assert property (p_keypins) else $error("key pin group wrong");
   property p_drive;
      (port8_drive_out != 8'h00) |-> !port8_segment_out;
   endproperty
   a_drive: assert property (p_drive) else $error("drive while in segment use");
   property p_p6;
      $past(nrst_in) |-> pullup_p6_out[3:0] == P6_LOW_PU;
   endproperty
   a_p6: assert property (p_p6) else $error("port 6 low pull-ups not the option");
   property p_rdata;
      cpu_rd_in && (cpu_addr_in inside {16'hff58, 16'hff59, 16'hff31}) |=> cpu_rdata_out == 8'h00;
   endproperty
   a_rdata: assert property (p_rdata) else $error("write-only or unmapped read not zero");
   property p_pu4;
      cpu_wr_in && !cpu_bit_in && cpu_addr_in == 16'hff34 |=> pullup_p4_out == $past(cpu_wdata_in);
   endproperty
   a_pu4: assert property (p_pu4) else $error("pull-up output not the written byte");
endmodule

bind ppc_top ppc_top_props #(.P6_LOW_PU(P6_LOW_PU)) u_props (.clk_in(clk_in), .nrst_in(nrst_in),
   .cpu_addr_in(cpu_addr_in), .cpu_wr_in(cpu_wr_in), .cpu_bit_in(cpu_bit_in),
   .cpu_wdata_in(cpu_wdata_in), .cpu_rd_in(cpu_rd_in), .cpu_rdata_out(cpu_rdata_out),
   .port4_pins_in(port4_pins_in), .pullup_p4_out(pullup_p4_out), .pullup_p6_out(pullup_p6_out),
   .port4_key_mode_out(port4_key_mode_out), .key_pins_out(key_pins_out),
   .key_return_out(key_return_out), .key_edge_out(key_edge_out),
   .port8_segment_out(port8_segment_out), .port8_drive_out(port8_drive_out));

// file: tb/ppc_top_test.sv
`timescale 1ns/1ps
`include "ppc_map.vh"
module ppc_top_test;
   reg         clk_in, nrst_in, cpu_wr_in, cpu_bit_in, cpu_rd_in;
   reg  [15:0] cpu_addr_in;
   reg  [2:0]  cpu_bit_sel_in;
   reg  [7:0]  cpu_wdata_in, press, dir8, dir9, seen, nret;
   wire [7:0]  pins, rdata, pu0, pu2, pu3, pu4, pu5, pu6, pu7, pullup_sel_port12, kpins, kedge, drv8, drv9;
   wire        kmode, kret, seg8, seg9;
   integer     num_errors, tests_run, cycles, i;
   reg  [15:0] pa [0:7];
   reg  [7:0]  pm [0:7];
   ppc_pin_model pad (.clk_in(clk_in), .press_in(press), .pins_out(pins));
   ppc_top #(.P6_LOW_PU(4'h5)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
      .cpu_addr_in(cpu_addr_in), .cpu_wr_in(cpu_wr_in), .cpu_bit_in(cpu_bit_in),
      .cpu_bit_sel_in(cpu_bit_sel_in), .cpu_wdata_in(cpu_wdata_in), .cpu_rd_in(cpu_rd_in),
      .cpu_rdata_out(rdata), .port4_pins_in(pins), .port8_direction_in(dir8),
      .port9_direction_in(dir9), .pullup_p0_out(pu0), .pullup_p2_out(pu2),
      .pullup_p3_out(pu3), .pullup_p4_out(pu4), .pullup_p5_out(pu5), .pullup_p6_out(pu6),
      .pullup_p7_out(pu7), .pullup_p12_out(pullup_sel_port12), .port4_key_mode_out(kmode),
      .key_pins_out(kpins), .key_return_out(kret), .key_edge_out(kedge),
      .port8_segment_out(seg8), .port9_segment_out(seg9), .port8_drive_out(drv8),
      .port9_drive_out(drv9));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task check(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [15:0] a, input [7:0] d, input b, input [2:0] s);
      begin
         @(posedge clk_in);
         cpu_addr_in <= a;
         cpu_wdata_in <= d;
         cpu_bit_in <= b;
         cpu_bit_sel_in <= s;
         cpu_wr_in <= 1'b1;
         @(posedge clk_in);
         cpu_wr_in <= 1'b0;
         repeat (2) @(posedge clk_in);
         #1;
      end
   endtask
   task rd(input [15:0] a, input [7:0] exp);
      begin
         @(posedge clk_in);
         cpu_addr_in <= a;
         cpu_rd_in <= 1'b1;
         @(posedge clk_in);
         cpu_rd_in <= 1'b0;
         #1 check(rdata, exp);
      end
   endtask
   // press keys for a few cycles and gather every edge pulse seen
   task hit(input [7:0] k);
      begin
         @(posedge clk_in);
         press <= k;
         seen = 8'h00;
         nret = 8'h00;
         repeat (5) begin
            @(posedge clk_in);
            #1 seen = seen | kedge;
            nret = nret + {7'h00, kret};
         end
         @(posedge clk_in);
         press <= 8'h00;
         repeat (2) @(posedge clk_in);
      end
   endtask
   task t_reset;
      begin
         for (i = 0; i < 8; i = i + 1) rd(pa[i], 8'h00);
         rd(`PPC_ADDR_P4MODE, 8'h00);
         rd(16'hff31, 8'h00);
         check({seg8, seg9, kmode, kret}, 4'b1100);
         check(drv8 | drv9, 8'h00);
         $display("reset test done");
      end
   endtask
   task t_pullup;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wr(pa[i], 8'hff, 1'b0, 3'h0);
            rd(pa[i], pm[i]);
         end
         check(pu0, `PPC_MASK_PU0);
         check(pu2, `PPC_MASK_PU2);
         check(pu5, `PPC_MASK_PU5);
         check({pu3[4:0], pullup_sel_port12[2:0]}, 8'hf9);
         check(pu6, 8'hf5);
         check(pu7, `PPC_MASK_PU7);
         // clear the driven pin's pull-up, as software must for an output pin
         wr(`PPC_ADDR_PU4, 8'h00, 1'b1, 3'h2);
         check(pu4, 8'hfb);
         $display("pull-up test done");
      end
   endtask
   task t_keyret;
      begin
         // mode set by a bit write of bit 0, upper mode bits stay at their reset zero
         wr(`PPC_ADDR_P4MODE, 8'h01, 1'b1, 3'h0);
         rd(`PPC_ADDR_P4MODE, 8'h01);
         check({7'h00, kmode}, 8'h01);
         check(kpins, `PPC_KR_ALL);
         hit(8'h40);
         check(seen, 8'h40);
         check(nret, 8'h01);
         // group register never read back, judged only by the pins it selects
         wr(`PPC_ADDR_KRGRP, 8'h01, 1'b0, 3'h0);
         check(kpins, `PPC_KR_LOW);
         hit(8'h81);
         check(seen, 8'h01);
         check(nret, 8'h01);
         wr(`PPC_ADDR_KRGRP, 8'h00, 1'b0, 3'h0);
         check(kpins, `PPC_KR_LOW);
         wr(`PPC_ADDR_P4MODE, 8'h00, 1'b0, 3'h0);
         hit(8'h01);
         check(seen | kpins, 8'h00);
         $display("key return test done");
      end
   endtask
   task t_pinfunc;
      begin
         wr(`PPC_ADDR_PF8, 8'h55, 1'b0, 3'h0);
         wr(`PPC_ADDR_PF8, 8'h01, 1'b1, 3'h0);
         check({7'h00, seg8}, 8'h01);
         // dedicated output: function all ones and every direction bit cleared
         @(posedge clk_in);
         dir8 <= 8'h00;
         wr(`PPC_ADDR_PF8, `PPC_PF_OUTPORT, 1'b0, 3'h0);
         check({seg8, drv8[6:0]}, 8'h7f);
         wr(`PPC_ADDR_PF8, `PPC_PF_SEGMENT, 1'b0, 3'h0);
         check(drv8, 8'hff);
         rd(`PPC_ADDR_PF8, 8'h00);
         @(posedge clk_in);
         dir9 <= 8'h00;
         wr(`PPC_ADDR_PF9, `PPC_PF_SEGMENT, 1'b0, 3'h0);
         wr(`PPC_ADDR_PF9, `PPC_PF_OUTPORT, 1'b0, 3'h0);
         check({7'h00, seg9} | drv9, 8'h01);
         $display("pin function test done");
      end
   endtask
   // a reset in mid-run must release the port 9 pin function and key group once-only locks
   task t_rerst;
      begin
         @(posedge clk_in);
         nrst_in <= 1'b0;
         repeat (3) @(posedge clk_in);
         nrst_in <= 1'b1;
         #1 check({seg9, kmode, pu4[0], pu6[4]}, 8'h08);
         wr(`PPC_ADDR_PF9, `PPC_PF_OUTPORT, 1'b0, 3'h0);
         check({7'h00, seg9}, 8'h00);
         check(drv9, 8'hff);
         check(pu6, 8'h05);
         wr(`PPC_ADDR_P4MODE, 8'h01, 1'b0, 3'h0);
         wr(`PPC_ADDR_KRGRP, 8'h01, 1'b0, 3'h0);
         check(kpins, `PPC_KR_LOW);
         $display("second reset test done");
      end
   endtask
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // ceiling well above the fewer than two hundred cycles the tests need
   always @(posedge clk_in) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         tally_and_finish;
      end
   end
   initial begin
      {cpu_wr_in, cpu_bit_in, cpu_rd_in, nrst_in} = 4'h0;
      {cpu_addr_in, cpu_bit_sel_in, cpu_wdata_in, press} = 35'h0;
      {dir8, dir9} = 16'hffff;
      {num_errors, tests_run, cycles} = 96'h0;
      {pa[0], pa[1], pa[2], pa[3]} = {16'hff30, 16'hff32, 16'hff33, 16'hff34};
      {pa[4], pa[5], pa[6], pa[7]} = {16'hff35, 16'hff36, 16'hff37, 16'hff3c};
      {pm[0], pm[1], pm[2], pm[3]} = {8'h3f, 8'h3f, 8'h1f, 8'hff};
      {pm[4], pm[5], pm[6], pm[7]} = {8'hff, 8'hf0, 8'h0f, 8'h01};
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_reset;
      t_pullup;
      t_keyret;
      t_pinfunc;
      t_rerst;
      tally_and_finish;
   end
endmodule
